// File: meter_far_side.sv
// Remote controller and analog front end model facing the port.
// Assumes pull-ups on range and function lines.
`timescale 1ns/10ps
`default_nettype none
module meter_far_side
    import meter_port_pkg::*;
#(
    parameter int DEINT = 30
) (
    input wire logic clk_sys_i,
    input wire logic pos_ref_i,
    input wire logic neg_ref_i,
    input wire logic [RANGE_N-1:0] range_oe_i,
    input wire logic [FUNC_N-1:0] func_oe_i,
    output logic ext_trigger_o,
    output logic comparator_o,
    output logic [RANGE_N-1:0] range_line_o,
    output logic [FUNC_N-1:0] func_line_o
);
    logic pol = 1'b1;
    logic flip = 1'b0;
    logic [RANGE_N-1:0] pull_r = 7'h00;
    logic [FUNC_N-1:0] pull_f = 4'h0;
    int cnt = 0;
    initial ext_trigger_o = 1'b0;
    // Open collector: any party pulling wins
    assign range_line_o = ~(range_oe_i | pull_r);
    assign func_line_o = ~(func_oe_i | pull_f);
    assign comparator_o = pol ^ flip;
    always @(posedge clk_sys_i) begin
        if (pos_ref_i || neg_ref_i) begin
            cnt <= cnt + 1;
            if (cnt == DEINT) flip <= 1'b1;
        end else begin
            cnt <= 0;
            flip <= 1'b0;
        end
    end
    task automatic fire(input int w);
        @(posedge clk_sys_i) ext_trigger_o <= 1'b1;
        repeat (w) @(posedge clk_sys_i);
        ext_trigger_o <= 1'b0;
    endtask : fire
endmodule : meter_far_side
`default_nettype wire

// File: meter_port_assertions.sv
// Checker for the remote BCD port, bound to the port's top module.
// Assumes one clock domain and sees top-level port signals only.
`timescale 1ns/10ps
`default_nettype none
module meter_port_assertions
    import meter_port_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ext_trigger_mode_i,
    input wire logic hold_n_i,
    input wire logic local_range_mode_i,
    input wire logic local_func_mode_i,
    input wire logic [DATA_W-1:0] bcd_data_o,
    input wire logic ready_o,
    input wire logic sample_integration_done_o,
    input wire logic read_command_o,
    input wire logic integrate_o,
    input wire logic zero_o,
    input wire logic positive_reference_select_o,
    input wire logic negative_reference_select_o,
    input wire logic range_local_flag_o,
    input wire logic func_local_flag_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // ****************************************
    // Conversion sequence
    // ****************************************
    // Six cycles covers the hold filter lag
    sequence held_s; (!hold_n_i && !ext_trigger_mode_i) [*6]; endsequence
    sequence deint_s; positive_reference_select_o || negative_reference_select_o; endsequence
    refs_exclusive_a: assert property (
        !(positive_reference_select_o && negative_reference_select_o)) else $error("both refs on");
    busy_low_a: assert property ((zero_o || integrate_o) |-> !ready_o)
        else $error("ready high while converting");
    read_start_a: assert property (
        read_command_o && ext_trigger_mode_i && ready_o |-> ##[1:3] (zero_o && !ready_o))
        else $error("read command started nothing");
    integ_end_a: assert property ($rose(sample_integration_done_o) |-> deint_s)
        else $error("integration flag without deintegration");
    ready_rise_a: assert property ($rose(ready_o) |-> $past(deint_s))
        else $error("ready rose outside deintegration");
    data_hold_a: assert property (
        ext_trigger_mode_i && ready_o && $past(ready_o) |-> $stable(bcd_data_o))
        else $error("result changed while idle");
    hold_idle_a: assert property (held_s ##0 ready_o |=> ready_o)
        else $error("conversion started under hold");
    zero_to_integ_a: assert property ($fell(zero_o) |-> integrate_o)
        else $error("auto-zero not followed by integration");
    local_flags_a: assert property (
        range_local_flag_o == local_range_mode_i && func_local_flag_o == local_func_mode_i)
        else $error("local control flag wrong");
endmodule : meter_port_assertions
bind meter_remote_bcd_control_port meter_port_assertions i_meter_port_assertions (
    .clk_sys_i, .sys_rst_i, .ext_trigger_mode_i, .hold_n_i, .local_range_mode_i,
    .local_func_mode_i, .bcd_data_o, .ready_o, .sample_integration_done_o, .read_command_o,
    .integrate_o, .zero_o, .positive_reference_select_o, .negative_reference_select_o,
    .range_local_flag_o, .func_local_flag_o);
`default_nettype wire

// File: meter_port_pkg.sv
// Package for the remote BCD control port of the bench meter.
// Assumes a single 40 MHz system clock; shared by the port logic.
package meter_port_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int TRIG_MIN_NS = 1000;
    localparam int TRIG_MAX_MS = 16;
    localparam int TRIG_MIN_CYC = (TRIG_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int TRIG_MAX_CYC = TRIG_MAX_MS * (CLK_HZ / 1000);
    localparam int AZ_CYC_DEF = 4000;
    localparam int INT_CYC_DEF = 4000;
    localparam int CNT_W = 24;

    // ****************************************
    // Field widths and reset values
    // ****************************************
    localparam int DATA_W = 17;
    localparam int RANGE_N = 7;
    localparam int FUNC_N = 4;
    localparam logic [RANGE_N-1:0] RANGE_IDLE = 7'h7F;
    localparam logic [FUNC_N-1:0] FUNC_IDLE = 4'hF;
    localparam logic [DATA_W-1:0] DATA_RST = 17'h00000;

    typedef enum logic [1:0] {
        PH_ZERO = 2'b00,
        PH_INTEG = 2'b01,
        PH_DEINT = 2'b10,
        PH_IDLE = 2'b11
    } phase_t;

    typedef struct packed {
        logic [DATA_W-1:0] bcd;
        logic positive;
        logic valid;
    } result_t;

    typedef struct packed {
        logic dc_volts_function;
        logic ac_volts_function;
        logic ohms_function;
        logic ratio_function;
    } func_sel_t;

endpackage : meter_port_pkg

// File: meter_remote_bcd_control_port.sv
// Remote parallel control and status port with conversion sequencer.
// Assumes comparator and trigger pins are asynchronous; range/function
// lines are open-drain: an enable high pulls the line low.
`timescale 1ns/10ps
`default_nettype none

module meter_remote_bcd_control_port
    import meter_port_pkg::*;
#(
    parameter int AZ_CYC = AZ_CYC_DEF,
    parameter int INT_CYC = INT_CYC_DEF,
    parameter int TRIG_MAX = TRIG_MAX_CYC
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ext_trigger_i,
    input wire logic ext_trigger_mode_i,
    input wire logic hold_n_i,
    input wire logic comparator_polarity_output_i,
    input wire logic local_range_mode_i,
    input wire logic [RANGE_N-1:0] local_range_i,
    input wire logic local_func_mode_i,
    input wire func_sel_t local_func_i,
    input wire logic range_ok_i,
    input wire logic [RANGE_N-1:0] range_line_i,
    input wire logic [FUNC_N-1:0] func_line_i,
    output logic [RANGE_N-1:0] range_line_oe_o,
    output logic [FUNC_N-1:0] func_line_oe_o,
    output logic range_local_flag_o,
    output logic func_local_flag_o,
    output logic [RANGE_N-1:0] remote_range_o,
    output logic [FUNC_N-1:0] remote_func_o,
    output logic [DATA_W-1:0] bcd_data_o,
    output logic positive_o,
    output logic [RANGE_N-1:0] range_status_o,
    output logic ready_o,
    output logic sample_integration_done_o,
    output logic data_valid_o,
    output logic read_command_o,
    output logic integrate_o,
    output logic zero_o,
    output logic positive_reference_select_o,
    output logic negative_reference_select_o
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [2:0] trig_sync;
        logic [2:0] comp_sync;
        logic [2:0] hold_sync;
        logic trig_level;
        logic comp_level;
        logic hold_level;
        logic [CNT_W-1:0] trig_width;
        logic read_cmd;
        phase_t phase;
        logic [CNT_W-1:0] count;
        logic start_pol;
        logic pos_ref;
        logic neg_ref;
        logic integ_done;
        logic ready;
        result_t result;
        logic [RANGE_N-1:0] range_used;
        logic [RANGE_N-1:0] range_in;
        logic [FUNC_N-1:0] func_in;
    } state_t;

    state_t st;
    state_t next_st;

    // Counts up BCD digits of the running deintegration count
    function automatic logic [DATA_W-1:0] bcd_inc(input logic [DATA_W-1:0] v);
        logic [DATA_W-1:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (carry) begin
                if (r[i*4 +: 4] == 4'h9) begin
                    r[i*4 +: 4] = 4'h0;
                end else begin
                    r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
        if (carry) begin
            r[16] = 1'b1;
        end
        return r;
    endfunction : bcd_inc

    // Majority-free filter: change accepted when stages two and three agree
    function automatic logic filt(input logic [2:0] s, input logic old);
        return (s[1] == s[2]) ? s[2] : old;
    endfunction : filt

    // ****************************************
    // Next state
    // ****************************************
    logic trig_fall;
    logic int_start;
    logic ext_start;
    logic comp_now;

    always_comb begin
        next_st = st;
        next_st.trig_sync = {st.trig_sync[1:0], ext_trigger_i};
        next_st.comp_sync = {st.comp_sync[1:0], comparator_polarity_output_i};
        next_st.hold_sync = {st.hold_sync[1:0], hold_n_i};
        next_st.trig_level = filt(st.trig_sync, st.trig_level);
        next_st.comp_level = filt(st.comp_sync, st.comp_level);
        next_st.hold_level = filt(st.hold_sync, st.hold_level);
        comp_now = st.comp_level;
        next_st.range_in = ~range_line_i;
        next_st.func_in = ~func_line_i;
        next_st.read_cmd = 1'b0;

        // Pulse width is judged at the falling edge, so a stuck-high line never fires
        trig_fall = st.trig_level && !next_st.trig_level;
        if (st.trig_level) begin
            if (st.trig_width != '1) begin
                next_st.trig_width = st.trig_width + 1'b1;
            end
        end else begin
            next_st.trig_width = '0;
        end
        if (trig_fall && st.trig_width >= CNT_W'(TRIG_MIN_CYC - 1)
            && st.trig_width < CNT_W'(TRIG_MAX)) begin
            next_st.read_cmd = 1'b1;
        end

        ext_start = st.read_cmd && ext_trigger_mode_i;
        int_start = !ext_trigger_mode_i && st.hold_level;

        case (st.phase)
            PH_IDLE: begin
                if (ext_start || int_start) begin
                    next_st.phase = PH_ZERO;
                    next_st.count = '0;
                    next_st.ready = 1'b0;
                    next_st.integ_done = 1'b0;
                end
            end
            PH_ZERO: begin
                next_st.count = st.count + 1'b1;
                if (st.count == CNT_W'(AZ_CYC - 1)) begin
                    next_st.phase = PH_INTEG;
                    next_st.count = '0;
                end
            end
            PH_INTEG: begin
                next_st.count = st.count + 1'b1;
                if (st.count == CNT_W'(INT_CYC - 1)) begin
                    next_st.phase = PH_DEINT;
                    next_st.count = '0;
                    next_st.integ_done = 1'b1;
                    next_st.start_pol = comp_now;
                    // Opposite reference to the input polarity; one only
                    next_st.neg_ref = comp_now;
                    next_st.pos_ref = !comp_now;
                    next_st.result.bcd = DATA_RST;
                end
            end
            PH_DEINT: begin
                next_st.result.bcd = bcd_inc(st.result.bcd);
                if (comp_now != st.start_pol) begin
                    next_st.phase = PH_IDLE;
                    next_st.pos_ref = 1'b0;
                    next_st.neg_ref = 1'b0;
                    next_st.ready = 1'b1;
                    next_st.result.bcd = st.result.bcd;
                    next_st.result.positive = st.start_pol;
                    next_st.result.valid = range_ok_i;
                    next_st.range_used = local_range_mode_i ? ~local_range_i
                                                            : ~st.range_in;
                end
            end
            default: begin
                next_st.phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st <= '0;
            st.phase <= PH_IDLE;
            st.hold_sync <= 3'h7;
            st.hold_level <= 1'b1;
            st.ready <= 1'b1;
            st.range_used <= RANGE_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign bcd_data_o = st.result.bcd;
    assign positive_o = st.result.positive;
    assign data_valid_o = st.result.valid;
    assign range_status_o = st.range_used;
    assign ready_o = st.ready;
    assign sample_integration_done_o = st.integ_done;
    assign read_command_o = st.read_cmd;
    assign zero_o = (st.phase == PH_ZERO);
    assign integrate_o = (st.phase == PH_INTEG);
    assign positive_reference_select_o = st.pos_ref;
    assign negative_reference_select_o = st.neg_ref;
    assign range_line_oe_o = local_range_mode_i ? local_range_i : '0;
    assign func_line_oe_o = local_func_mode_i ? local_func_i : '0;
    assign range_local_flag_o = local_range_mode_i;
    assign func_local_flag_o = local_func_mode_i;
    // Remote selections, active high; lines pulled low by the remote party
    assign remote_range_o = local_range_mode_i ? '0 : st.range_in;
    assign remote_func_o = local_func_mode_i ? '0 : st.func_in;

endmodule : meter_remote_bcd_control_port

`default_nettype wire

// File: meter_remote_bcd_control_port_tb.sv
// Testbench for the remote BCD port with the far-side model.
// Assumes shortened sequencer counts set below.
`timescale 1ns/10ps
`default_nettype none
module meter_remote_bcd_control_port_tb
    import meter_port_pkg::*;
;
    logic clk_sys_i = 0, sys_rst_i = 1, ext_trigger_mode_i = 1, hold_n_i = 1, range_ok_i = 1;
    logic local_range_mode_i = 1, local_func_mode_i = 1;
    logic [RANGE_N-1:0] local_range_i = 7'h04;
    func_sel_t local_func_i = 4'h8;
    logic [RANGE_N-1:0] range_line_i, range_line_oe_o, remote_range_o, range_status_o;
    logic [FUNC_N-1:0] func_line_i, func_line_oe_o, remote_func_o;
    logic [DATA_W-1:0] bcd_data_o, last;
    logic ext_trigger_i, comparator_polarity_output_i, positive_o, ready_o, data_valid_o;
    logic read_command_o, pos_ref, neg_ref;
    int fails = 0, compares = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    meter_remote_bcd_control_port #(.AZ_CYC(20), .INT_CYC(20), .TRIG_MAX(2000))
    i_meter_remote_bcd_control_port (.clk_sys_i, .sys_rst_i, .ext_trigger_i,
        .ext_trigger_mode_i, .hold_n_i, .comparator_polarity_output_i, .local_range_mode_i,
        .local_range_i, .local_func_mode_i, .local_func_i, .range_ok_i, .range_line_i,
        .func_line_i, .range_line_oe_o, .func_line_oe_o, .range_local_flag_o(),
        .func_local_flag_o(), .remote_range_o, .remote_func_o, .bcd_data_o, .positive_o,
        .range_status_o, .ready_o, .sample_integration_done_o(), .data_valid_o,
        .read_command_o, .integrate_o(), .zero_o(), .positive_reference_select_o(pos_ref),
        .negative_reference_select_o(neg_ref));
    meter_far_side i_far (.clk_sys_i, .pos_ref_i(pos_ref), .neg_ref_i(neg_ref),
        .range_oe_i(range_line_oe_o), .func_oe_i(func_line_oe_o), .ext_trigger_o(ext_trigger_i),
        .comparator_o(comparator_polarity_output_i), .range_line_o(range_line_i),
        .func_line_o(func_line_i));
    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        #1 compares++;
        if (e !== s) begin
            fails++;
            $display("FAIL %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk
    task automatic run(input int w, input logic p, input logic ok, input logic [6:0] r);
        int i;
        i_far.pol <= p;
        range_ok_i <= ok;
        local_range_i <= r;
        i_far.fire(w);
        for (i = 0; i < 100 && ready_o; i++) @(posedge clk_sys_i);
        for (i = 0; i < 500 && !ready_o; i++) @(posedge clk_sys_i);
        chk("ready", 1, ready_o);
        chk("sign", p, positive_o);
        chk("valid", ok, data_valid_o);
        chk("range", 7'(~r), range_status_o);
        chk("range line", 7'(~r), range_line_i);
        for (i = 0; i < 4; i++) chk("digit", 1, bcd_data_o[4*i+:4] <= 4'h9);
        last = bcd_data_o;
        repeat (200) @(posedge clk_sys_i);
        chk("held data", last, bcd_data_o);
    endtask : run
    task automatic t_width(input int w, input logic go);
        logic lo;
        lo = 0;
        i_far.fire(w);
        repeat (150) @(posedge clk_sys_i) lo |= !ready_o;
        chk("trigger width", go, lo);
    endtask : t_width
    task automatic t_hold();
        logic lo;
        lo = 0;
        hold_n_i <= 0;
        repeat (5) @(posedge clk_sys_i);
        ext_trigger_mode_i <= 0;
        repeat (300) @(posedge clk_sys_i) lo |= !ready_o;
        chk("held idle", 0, lo);
        hold_n_i <= 1;
        repeat (20) @(posedge clk_sys_i) lo |= !ready_o;
        chk("auto start", 1, lo);
        ext_trigger_mode_i <= 1;
        repeat (300) @(posedge clk_sys_i);
    endtask : t_hold
    task automatic t_remote();
        chk("local func line", 4'h7, func_line_i);
        local_range_mode_i <= 0;
        local_func_mode_i <= 0;
        i_far.pull_r <= 7'h02;
        i_far.pull_f <= 4'h4;
        repeat (5) @(posedge clk_sys_i);
        chk("remote range", 7'h02, remote_range_o);
        chk("remote func", 4'h4, remote_func_o);
        chk("func line", 4'hB, func_line_i);
    endtask : t_remote
    // ****************************************
    // Sequence and verdict
    // ****************************************
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    initial begin
        repeat (12) @(posedge clk_sys_i);
        sys_rst_i <= 0;
        repeat (3) @(posedge clk_sys_i);
        run(100, 1, 1, 7'h04);
        run(40, 0, 0, 7'h40);
        t_width(10, 0);
        t_width(3000, 0);
        t_width(40, 1);
        t_hold();
        t_remote();
        results();
    end
    // Generous bound on the whole sequence
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        results();
    end
endmodule : meter_remote_bcd_control_port_tb
`default_nettype wire
